// [include/irq_pulse_pkg.sv]
// package for the interrupt pulse logic: source layout, pulse widths, types
package irq_pulse_pkg;

  // ****************************************
  // source layout
  // ****************************************
  localparam int NUM_SRC = 40;
  localparam int IO_BITS = 5;
  localparam int SRC_BAT_LOW = 0;
  localparam int SRC_SUP_LOW = 1;
  localparam int SRC_REF_TMO = 2;
  localparam int SRC_AUX_TMO = 3;
  localparam int SRC_REF_TWARN = 4;
  localparam int SRC_CANBUS_OVERTEMP = 5;
  localparam int SRC_LINBUS_OVERTEMP = 6;
  localparam int SRC_IO_CHG = 7;
  localparam int SRC_IO_WU = 12;
  localparam int SRC_CANBUS_WAKEUP = 17;
  localparam int SRC_LINBUS_WAKEUP = 18;
  localparam int SRC_CAN_TXD = 19;
  localparam int SRC_CAN_RXD = 20;
  localparam int SRC_CAN_BUS = 21;
  localparam int SRC_LIN_TXD = 22;
  localparam int SRC_LIN_RXD = 23;
  localparam int SRC_LIN_BUS = 24;
  localparam int SRC_SW_REQ = 25;
  localparam int SRC_LDT = 26;
  localparam int SRC_SPI_SEC = 27;
  localparam int SRC_SPI_CLK = 28;
  localparam int SRC_SPI_REQ = 29;
  localparam int SRC_SPI_PAR = 30;
  localparam int SRC_CONV_CHG = 31;
  localparam int SRC_BOB_CHG = 32;
  localparam int SRC_RES_LO = 33;

  // ****************************************
  // spi framing and pulse timing
  // ****************************************
  localparam logic [4:0] SPI_FRAME_CLKS = 5'h10;
  localparam int CLK_MHZ = 20;
  localparam int PULSE_SHORT_US = 25;
  localparam int PULSE_LONG_US = 100;
  localparam logic [11:0] PULSE_SHORT_CYC = 12'(PULSE_SHORT_US * CLK_MHZ);
  localparam logic [11:0] PULSE_LONG_CYC = 12'(PULSE_LONG_US * CLK_MHZ);
  localparam logic [NUM_SRC-1:0] MASK_RST = '0;
  localparam logic [NUM_SRC-1:0] FLAG_RST = '0;
  localparam logic [2:0] CONV_RST = 3'h0;

  typedef logic [NUM_SRC-1:0] src_vec_t;

  // raw event inputs from the detectors
  typedef struct packed {
    logic battery_sense_low;
    logic supply_low;
    logic ref_reg_limit_timeout;
    logic aux_reg_limit_timeout;
    logic ref_reg_temp_warning;
    logic ref_reg_internal_pass;
    logic canbus_overtemp;
    logic linbus_overtemp;
    logic [IO_BITS-1:0] line_wakeup;
    logic canbus_wakeup;
    logic linbus_wakeup;
    logic can_tx_stuck_dominant;
    logic can_rx_stuck_recessive;
    logic canbus_stuck_dominant;
    logic lin_tx_stuck_dominant;
    logic lin_rx_stuck_recessive;
    logic linbus_stuck_dominant;
    logic long_timer_expired;
    logic secured_check_fail;
  } detect_t;

  // spi frame summary from the serial front end, valid on frame_done
  typedef struct packed {
    logic frame_done;
    logic [5:0] clk_count;
    logic parity_ok;
    logic malformed;
    logic addr_unknown;
    logic write_init_reg;
    logic is_write;
    logic sw_irq_req;
  } spi_frame_t;

  typedef enum logic [1:0] {
    PH_INIT,
    PH_NORMAL
  } phase_t;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_LOW,
    PS_GAP
  } pulse_state_t;

  typedef struct packed {
    pulse_state_t st;
    logic [11:0] cnt;
    logic out_n;
  } pulse_t;

endpackage

// [rtl/irq_pulse_gen.sv]
// one-shot low pulse generator for the interrupt line
`timescale 1ns/1ns
module irq_pulse_gen
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic fire_i,
  input wire logic long_i,
  // pin and busy status
  output logic irq_out_n_o,
  output logic busy_o
);

  irq_pulse_pkg::pulse_t state_ff;
  irq_pulse_pkg::pulse_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff.st)
      irq_pulse_pkg::PS_IDLE:
      begin
        if (fire_i)
        begin
          // drive low, then release after width
          nxt_state.st = irq_pulse_pkg::PS_LOW;
          nxt_state.out_n = 1'b0;
          nxt_state.cnt = long_i ? irq_pulse_pkg::PULSE_LONG_CYC
                                 : irq_pulse_pkg::PULSE_SHORT_CYC;
        end
      end
      irq_pulse_pkg::PS_LOW:
      begin
        nxt_state.cnt = state_ff.cnt - 12'h001;
        if (state_ff.cnt == 12'h001)
        begin
          // one high cycle so back-to-back pulses stay separable
          nxt_state.st = irq_pulse_pkg::PS_GAP;
          nxt_state.out_n = 1'b1;
        end
      end
      irq_pulse_pkg::PS_GAP:
      begin
        nxt_state.st = irq_pulse_pkg::PS_IDLE;
      end
      default:
      begin
        nxt_state.st = irq_pulse_pkg::PS_IDLE;
        nxt_state.out_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= '{st: irq_pulse_pkg::PS_IDLE, cnt: 12'h000, out_n: 1'b1};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign irq_out_n_o = state_ff.out_n;
  assign busy_o = (state_ff.st != irq_pulse_pkg::PS_IDLE);

endmodule // irq_pulse_gen

// [rtl/irq_collector.sv]
// interrupt source collector with latched flags and pulse request queue
`timescale 1ns/1ns
module irq_collector
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // detector events
  input wire irq_pulse_pkg::detect_t detect_i,
  input wire logic [irq_pulse_pkg::IO_BITS-1:0] line_level_i,
  input wire logic [2:0] conv_active_i,
  input wire logic buck_or_boost_state_i,
  // spi side
  input wire irq_pulse_pkg::spi_frame_t spi_i,
  input wire logic init_done_i,
  input wire logic cfg_write_i,
  input wire logic cfg_long_pulse_i,
  input wire logic cfg_pulse_enable_i,
  input wire irq_pulse_pkg::src_vec_t cfg_mask_i,
  input wire logic flag_read_i,
  input wire irq_pulse_pkg::src_vec_t flag_read_sel_i,
  // status and pin
  output irq_pulse_pkg::src_vec_t flags_o,
  output logic [2:0] conv_active_o,
  output logic buck_or_boost_state_o,
  output logic init_phase_o,
  output logic irq_out_n_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    irq_pulse_pkg::phase_t phase;
    logic in_init;
    logic long_pulse;
    logic pulse_en;
    irq_pulse_pkg::src_vec_t mask;
    irq_pulse_pkg::src_vec_t flags;
    irq_pulse_pkg::src_vec_t src_prev;
    logic [irq_pulse_pkg::IO_BITS-1:0] line_prev;
    logic line_seen;
    logic [2:0] conv;
    logic buck_or_boost_state;
    logic pending;
    logic fire;
  } coll_t;

  coll_t state_ff;
  coll_t nxt_state;
  irq_pulse_pkg::src_vec_t src;
  logic [irq_pulse_pkg::IO_BITS-1:0] line_chg;
  logic pulse_busy;
  logic pulse_pin;

  // ****************************************
  // source vector
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < irq_pulse_pkg::IO_BITS; gi++)
    begin : g_line
      // level change per monitored line
      assign line_chg[gi] = state_ff.line_seen &
                            (line_level_i[gi] ^ state_ff.line_prev[gi]);
      assign src[irq_pulse_pkg::SRC_IO_CHG + gi] = line_chg[gi];
      assign src[irq_pulse_pkg::SRC_IO_WU + gi] = detect_i.line_wakeup[gi];
    end
  endgenerate

  logic frm;
  assign frm = spi_i.frame_done;
  assign src[irq_pulse_pkg::SRC_BAT_LOW] = detect_i.battery_sense_low;
  assign src[irq_pulse_pkg::SRC_SUP_LOW] = detect_i.supply_low;
  assign src[irq_pulse_pkg::SRC_REF_TMO] = detect_i.ref_reg_limit_timeout;
  assign src[irq_pulse_pkg::SRC_AUX_TMO] = detect_i.aux_reg_limit_timeout;
  assign src[irq_pulse_pkg::SRC_REF_TWARN] = detect_i.ref_reg_temp_warning &
                                         detect_i.ref_reg_internal_pass;
  assign src[irq_pulse_pkg::SRC_CANBUS_OVERTEMP] = detect_i.canbus_overtemp;
  assign src[irq_pulse_pkg::SRC_LINBUS_OVERTEMP] = detect_i.linbus_overtemp;
  assign src[irq_pulse_pkg::SRC_CANBUS_WAKEUP] = detect_i.canbus_wakeup;
  assign src[irq_pulse_pkg::SRC_LINBUS_WAKEUP] = detect_i.linbus_wakeup;
  assign src[irq_pulse_pkg::SRC_CAN_TXD] = detect_i.can_tx_stuck_dominant;
  assign src[irq_pulse_pkg::SRC_CAN_RXD] = detect_i.can_rx_stuck_recessive;
  assign src[irq_pulse_pkg::SRC_CAN_BUS] = detect_i.canbus_stuck_dominant;
  assign src[irq_pulse_pkg::SRC_LIN_TXD] = detect_i.lin_tx_stuck_dominant;
  assign src[irq_pulse_pkg::SRC_LIN_RXD] = detect_i.lin_rx_stuck_recessive;
  assign src[irq_pulse_pkg::SRC_LIN_BUS] = detect_i.linbus_stuck_dominant;
  assign src[irq_pulse_pkg::SRC_SW_REQ] = frm & spi_i.sw_irq_req;
  assign src[irq_pulse_pkg::SRC_LDT] = detect_i.long_timer_expired;
  assign src[irq_pulse_pkg::SRC_SPI_SEC] = detect_i.secured_check_fail;
  // frame checks taken once per frame, on its done strobe only
  assign src[irq_pulse_pkg::SRC_SPI_CLK] = frm &
    (spi_i.clk_count != {1'b0, irq_pulse_pkg::SPI_FRAME_CLKS});
  assign src[irq_pulse_pkg::SRC_SPI_REQ] = frm & (spi_i.malformed | spi_i.addr_unknown |
    (spi_i.is_write & spi_i.write_init_reg &
     (state_ff.phase == irq_pulse_pkg::PH_NORMAL)));
  assign src[irq_pulse_pkg::SRC_SPI_PAR] = frm & ~spi_i.parity_ok;
  assign src[irq_pulse_pkg::SRC_CONV_CHG] = |(conv_active_i ^ state_ff.conv);
  assign src[irq_pulse_pkg::SRC_BOB_CHG] = buck_or_boost_state_i ^ state_ff.buck_or_boost_state;
  assign src[irq_pulse_pkg::NUM_SRC-1:irq_pulse_pkg::SRC_RES_LO] = '0;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    irq_pulse_pkg::src_vec_t rise;
    irq_pulse_pkg::src_vec_t clr;
    rise = '0;
    clr = '0;
    nxt_state = state_ff;
    // settings only accepted while in init phase
    if (state_ff.phase == irq_pulse_pkg::PH_INIT)
    begin
      if (cfg_write_i)
      begin
        nxt_state.long_pulse = cfg_long_pulse_i;
        nxt_state.pulse_en = cfg_pulse_enable_i;
        nxt_state.mask = cfg_mask_i;
      end
      if (init_done_i)
      begin
        nxt_state.phase = irq_pulse_pkg::PH_NORMAL;
        nxt_state.in_init = 1'b0;
      end
    end
    // new assertions only, so a held level fires once
    rise = src & ~state_ff.src_prev;
    nxt_state.src_prev = src;
    nxt_state.line_prev = line_level_i;
    nxt_state.line_seen = 1'b1;
    nxt_state.conv = conv_active_i;
    nxt_state.buck_or_boost_state = buck_or_boost_state_i;
    // read clears, a same-cycle set wins
    if (flag_read_i)
    begin
      clr = flag_read_sel_i;
    end
    nxt_state.flags = (state_ff.flags & ~clr) | rise;
    // unmasked rises queue one pulse; merged while one is running
    nxt_state.fire = 1'b0;
    if ((|(rise & ~state_ff.mask)) && state_ff.pulse_en)
    begin
      nxt_state.pending = 1'b1;
    end
    if (state_ff.pending && !pulse_busy && !state_ff.fire)
    begin
      nxt_state.fire = 1'b1;
      nxt_state.pending = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // power-on reset clears flags, mask and long-pulse setting; pulse enable resets to on
      state_ff <= '{phase: irq_pulse_pkg::PH_INIT, in_init: 1'b1, long_pulse: 1'b0,
                    pulse_en: 1'b1,
                    mask: irq_pulse_pkg::MASK_RST, flags: irq_pulse_pkg::FLAG_RST,
                    src_prev: '0, line_prev: '0, line_seen: 1'b0,
                    conv: irq_pulse_pkg::CONV_RST, buck_or_boost_state: 1'b0, pending: 1'b0,
                    fire: 1'b0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // pulse output
  // ****************************************
  irq_pulse_gen u_pulse
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fire_i(state_ff.fire),
    .long_i(state_ff.long_pulse),
    .irq_out_n_o(pulse_pin),
    .busy_o(pulse_busy)
  );

  assign irq_out_n_o = pulse_pin;
  assign flags_o = state_ff.flags;
  assign conv_active_o = state_ff.conv;
  assign buck_or_boost_state_o = state_ff.buck_or_boost_state;
  assign init_phase_o = state_ff.in_init;

endmodule // irq_collector

// [sim/irq_collector_checker.sv]
// checker for the interrupt collector ports
`timescale 1ns/1ns
module irq_collector_checker
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire irq_pulse_pkg::detect_t detect_i,
  input wire irq_pulse_pkg::spi_frame_t spi_i,
  input wire logic [2:0] conv_active_i,
  input wire logic init_done_i,
  input wire irq_pulse_pkg::src_vec_t flags_o,
  input wire logic [2:0] conv_active_o,
  input wire logic init_phase_o,
  input wire logic irq_out_n_o
);
  // ****
  // low time counter
  // ****
  // too long for a repetition, so counted here
  logic [11:0] low_ff;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) low_ff <= 12'h0;
    else if (!irq_out_n_o) low_ff <= low_ff + 12'h1;
    else low_ff <= 12'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // properties
  // ****
  AST_WIDTH:
    assert property ($rose(irq_out_n_o) |-> low_ff == irq_pulse_pkg::PULSE_SHORT_CYC
      || low_ff == irq_pulse_pkg::PULSE_LONG_CYC) else $error("pulse width off");
  AST_GAP:
    assert property ($rose(irq_out_n_o) |=> irq_out_n_o) else $error("gap too short");
  AST_BAT:
    assert property ($rose(detect_i.battery_sense_low) |-> ##2
      flags_o[irq_pulse_pkg::SRC_BAT_LOW]) else $error("battery flag missing");
  AST_CANWU:
    assert property ($rose(detect_i.canbus_wakeup) |-> ##2
      flags_o[irq_pulse_pkg::SRC_CANBUS_WAKEUP]) else $error("can wake flag missing");
  AST_LDT:
    assert property ($rose(detect_i.long_timer_expired) |-> ##2
      flags_o[irq_pulse_pkg::SRC_LDT]) else $error("timer flag missing");
  AST_CLK:
    assert property (spi_i.frame_done && spi_i.clk_count != 6'h10 |-> ##2
      flags_o[irq_pulse_pkg::SRC_SPI_CLK]) else $error("clock count flag missing");
  AST_PAR:
    assert property (spi_i.frame_done && !spi_i.parity_ok |-> ##2
      flags_o[irq_pulse_pkg::SRC_SPI_PAR]) else $error("parity flag missing");
  AST_INIT:
    assert property (init_done_i |-> ##2 !init_phase_o) else $error("init not left");
  AST_ONEWAY:
    assert property (!init_phase_o |=> !init_phase_o) else $error("init re-entered");
  AST_CONV:
    assert property (conv_active_o == $past(conv_active_i)) else $error("conv copy off");
  AST_TWARN:
    assert property ($rose(detect_i.ref_reg_temp_warning) && !detect_i.ref_reg_internal_pass
      && !flags_o[irq_pulse_pkg::SRC_REF_TWARN] |=>
      !flags_o[irq_pulse_pkg::SRC_REF_TWARN]) else $error("ungated warning");
endmodule // irq_collector_checker

bind irq_collector irq_collector_checker chk (.*);

// [sim/mcu_model.sv]
// microcontroller model that watches the interrupt line
`timescale 1ns/1ns
module mcu_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin
  input wire logic irq_out_n_i,
  // observed pulses
  output logic [7:0] pulses_o,
  output logic [11:0] width_o
);
  logic [11:0] run_ff;
  // counts each finished low pulse and its length
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      run_ff <= 12'h0;
      pulses_o <= 8'h0;
      width_o <= 12'h0;
    end
    else if (!irq_out_n_i) run_ff <= run_ff + 12'h1;
    else if (run_ff != 12'h0)
    begin
      pulses_o <= pulses_o + 8'h1;
      width_o <= run_ff;
      run_ff <= 12'h0;
    end
endmodule // mcu_model

// [sim/irq_collector_bench.sv]
// self-checking testbench for the interrupt collector
`timescale 1ns/1ns
module irq_collector_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  irq_pulse_pkg::detect_t det = '0;
  irq_pulse_pkg::spi_frame_t spi = '0;
  irq_pulse_pkg::src_vec_t mask = '0;
  irq_pulse_pkg::src_vec_t sel = '0;
  irq_pulse_pkg::src_vec_t flags;
  logic [4:0] lvl = 5'h0;
  logic [2:0] conv = 3'h0;
  logic [2:0] conv_o;
  logic buck_or_boost_state = 1'b0, init_done = 1'b0, cfg_write = 1'b0, cfg_long = 1'b0, rd = 1'b0;
  logic pen = 1'b1;
  logic bob_o, init_ph, irq_n;
  logic [7:0] pulses;
  logic [11:0] width;
  int err_total = 0;
  int num_checks = 0;
  always #25 clk_i = ~clk_i;
  irq_collector DUT (.clk_i(clk_i), .rst_i(rst_i), .detect_i(det), .line_level_i(lvl),
    .conv_active_i(conv), .buck_or_boost_state_i(buck_or_boost_state), .spi_i(spi),
    .init_done_i(init_done), .cfg_write_i(cfg_write), .cfg_long_pulse_i(cfg_long),
    .cfg_pulse_enable_i(pen), .cfg_mask_i(mask), .flag_read_i(rd),
    .flag_read_sel_i(sel), .flags_o(flags), .conv_active_o(conv_o),
    .buck_or_boost_state_o(bob_o), .init_phase_o(init_ph), .irq_out_n_o(irq_n));
  mcu_model mcu (.clk_i(clk_i), .rst_i(rst_i), .irq_out_n_i(irq_n), .pulses_o(pulses),
    .width_o(width));
  // ****
  // tasks
  // ****
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // merged rises may add one more pulse, so wait for a long high stretch
  task automatic quiet();
    int h;
    h = 0;
    for (int i = 0; i < 5000 && h < 20; i++)
    begin
      @(posedge clk_i);
      h = irq_n ? h + 1 : 0;
    end
  endtask
  // one frame summary; host keeps 16 clocks unless a count error is wanted
  // acc: malformed, unknown address, init register, write
  task automatic frame(input logic [5:0] n, input logic par, input logic [3:0] acc,
    input logic swq);
    spi <= {1'b1, n, par, acc, swq};
    tick(1);
    spi <= '0;
    tick(1);
  endtask
  task automatic results();
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    tick(12);
    rst_i <= 1'b0;
    tick(1);
    chk("flags", flags, '0);
    chk("irq", irq_n, 1'b1);
    chk("init", init_ph, 1'b1);
    mask[irq_pulse_pkg::SRC_CANBUS_WAKEUP] <= 1'b1;
    pen <= 1'b0;
    cfg_write <= 1'b1;
    tick(1);
    cfg_write <= 1'b0;
    det.linbus_overtemp <= 1'b1;
    tick(8);
    chk("linbus_overtemp", flags[irq_pulse_pkg::SRC_LINBUS_OVERTEMP], 1'b1);
    chk("disabled", irq_n, 1'b1);
    pen <= 1'b1;
    cfg_long <= 1'b1;
    cfg_write <= 1'b1;
    tick(1);
    cfg_write <= 1'b0;
    det.battery_sense_low <= 1'b1;
    tick(6);
    chk("bat", flags[irq_pulse_pkg::SRC_BAT_LOW], 1'b1);
    chk("irq low", irq_n, 1'b0);
    quiet();
    chk("no extra", pulses, 8'h1);
    chk("width", width, irq_pulse_pkg::PULSE_LONG_CYC);
    // back to short pulses while still in init
    cfg_long <= 1'b0;
    cfg_write <= 1'b1;
    tick(1);
    cfg_write <= 1'b0;
    det.canbus_wakeup <= 1'b1;
    det.ref_reg_temp_warning <= 1'b1;
    tick(30);
    chk("canbus_wakeup", flags[irq_pulse_pkg::SRC_CANBUS_WAKEUP], 1'b1);
    chk("twarn", flags[irq_pulse_pkg::SRC_REF_TWARN], 1'b0);
    chk("masked", pulses, 8'h1);
    det <= '1;
    tick(6);
    chk("all", flags & ~(40'h1 << irq_pulse_pkg::SRC_REF_TWARN), 40'h000dfff06f);
    quiet();
    chk("one pulse", pulses, 8'h2);
    lvl <= 5'h04;
    tick(6);
    chk("io chg", flags[irq_pulse_pkg::SRC_IO_CHG+2], 1'b1);
    quiet();
    frame(6'h10, 1'b1, 4'h3, 1'b0);
    tick(4);
    chk("init write", flags[irq_pulse_pkg::SRC_SPI_REQ], 1'b0);
    init_done <= 1'b1;
    tick(3);
    chk("normal", init_ph, 1'b0);
    cfg_long <= 1'b1;
    mask <= '0;
    cfg_write <= 1'b1;
    rd <= 1'b1;
    sel[irq_pulse_pkg::SRC_CANBUS_WAKEUP] <= 1'b1;
    det.canbus_wakeup <= 1'b0;
    tick(1);
    cfg_write <= 1'b0;
    rd <= 1'b0;
    tick(3);
    chk("cleared", flags[irq_pulse_pkg::SRC_CANBUS_WAKEUP], 1'b0);
    det.canbus_wakeup <= 1'b1;
    tick(30);
    chk("still masked", pulses, 8'h3);
    frame(6'h10, 1'b1, 4'h0, 1'b0);
    tick(4);
    chk("clean", flags[30:28], 3'h0);
    frame(6'h0f, 1'b1, 4'h0, 1'b0);
    frame(6'h10, 1'b0, 4'h0, 1'b0);
    frame(6'h10, 1'b1, 4'h8, 1'b0);
    tick(4);
    chk("spi errs", flags[30:28], 3'h7);
    rd <= 1'b1;
    sel <= 40'h1 << irq_pulse_pkg::SRC_SPI_REQ;
    tick(1);
    rd <= 1'b0;
    tick(2);
    chk("req clr", flags[irq_pulse_pkg::SRC_SPI_REQ], 1'b0);
    frame(6'h10, 1'b1, 4'h3, 1'b0);
    tick(4);
    chk("normal write", flags[irq_pulse_pkg::SRC_SPI_REQ], 1'b1);
    quiet();
    frame(6'h10, 1'b1, 4'h0, 1'b1);
    tick(5);
    chk("sw req", irq_n, 1'b0);
    quiet();
    chk("sw width", width, irq_pulse_pkg::PULSE_SHORT_CYC);
    conv <= 3'h5;
    buck_or_boost_state <= 1'b1;
    tick(3);
    chk("conv", conv_o, 3'h5);
    chk("bob", bob_o, 1'b1);
    quiet();
    results();
  end
  initial
  begin
    tick(60000);
    err_total++;
    results();
  end
endmodule // irq_collector_bench
